// ---- core/bwd_pkg.sv ----
package bwd_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CELLS = 12;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_BAL_EN = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_WDOG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PIN = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DCHG_SEL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_DCFG = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

  // field positions
  localparam int WDOG_PSEL_LSB = 0;
  localparam int WDOG_CNT_LSB = 4;
  localparam int PIN_TMR_SEL_BIT = 0;
  localparam int PIN_LVL_BIT = 1;
  localparam int PIN_OE_BIT = 2;
  localparam int DCFG_TIME_LSB = 0;
  localparam int DCFG_WIN_LSB = 8;
  localparam int DCFG_EN_BIT = 16;
  localparam int ST_HB_LSB = 0;
  localparam int ST_ACT_BIT = 4;
  localparam int ST_DONE_BIT = 5;
  localparam int ST_EXP_BIT = 6;
  localparam int ST_ODD_BIT = 7;
  localparam int ST_SW_LSB = 8;
  localparam int ST_PIN_BIT = 20;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // time base: one base tick per 62.5 ms
  localparam int CLK_FREQ_KHZ = 25000;
  localparam int TICK_PERIOD_US = 62500;
  localparam int CYC_PER_TICK_DFLT = (TICK_PERIOD_US * CLK_FREQ_KHZ) / 1000;
  localparam logic [3:0] TICKS_PER_SEC_M1 = 4'hf;
  localparam logic [2:0] TICKS_PER_HB_M1 = 3'h7;
  localparam logic [9:0] TICKS_PER_MIN_M1 = 10'h3bf;
  localparam logic [10:0] TICKS_PER_WIN_STEP = 11'h078;
  localparam logic [16:0] TICKS_PER_2H_M1 = 17'h1c1ff;

  // prescale periods in seconds
  localparam logic [8:0] PSC_1S = 9'h001;
  localparam logic [8:0] PSC_4S = 9'h004;
  localparam logic [8:0] PSC_16S = 9'h010;
  localparam logic [8:0] PSC_64S = 9'h040;
  localparam logic [8:0] PSC_128S = 9'h080;
  localparam logic [8:0] PSC_256S = 9'h100;

  // cells 1,3,5.. sit on bits 0,2,4..
  localparam logic [NUM_CELLS-1:0] ODD_CELL_MASK = 12'h555;

  typedef struct packed {
    logic [NUM_CELLS-1:0] bal_en;
    logic [2:0] psel;
    logic [3:0] cnt;
    logic tmr_sel;
    logic pin_lvl;
    logic pin_oe;
    logic [NUM_CELLS-1:0] dchg_sel;
    logic [7:0] dtime;
    logic [2:0] dwin;
    logic emg_en;
    logic [3:0] sub_sec;
    logic [8:0] sec_cnt;
    logic emg_act;
    logic emg_done;
    logic odd;
    logic [9:0] win_cnt;
    logic [2:0] hb_sub;
    logic [3:0] hb;
    logic [16:0] h2_cnt;
    logic [8:0] h2_units;
    logic [NUM_CELLS-1:0] sw;
    logic pin_o;
    logic pin_oe_o;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
  } bwd_state_t;

endpackage : bwd_pkg

// ---- core/bwd_tick.sv ----
`timescale 1ns/1ps
module bwd_tick #(
  parameter int CYC_PER_TICK = 1562500
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  output logic o_tick
);
  localparam int CW = $clog2(CYC_PER_TICK);

  generate
    if (CYC_PER_TICK < 2) begin : g_chk
      $error("CYC_PER_TICK must be at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } bwd_tick_t;

  bwd_tick_t r_reg;
  bwd_tick_t r_next;

  // free-running base tick, cleared with the rest of the device
  always_comb begin
    r_next = r_reg;
    r_next.tick = 1'b0;
    if (r_reg.cnt == CW'(CYC_PER_TICK - 1)) begin
      r_next.cnt = '0;
      r_next.tick = 1'b1;
    end else begin
      r_next.cnt = r_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_tick = r_reg.tick;
endmodule : bwd_tick

// ---- core/bwd_core.sv ----
// Function
// - outside discharge, watchdog expiry forces all switches off; switch enable register keeps its contents.
// - prescale select 000b disables; 001b..110b give 1,4,16,64,128,256 s ticks.
// - countdown decrements once per prescale tick; timeout is value times period.
// - after reaching zero switches stay off until timer disabled or reloaded non-zero.
// - with timer-output select set, pin three is high while the countdown runs.
// - discharge starts only with enable set and timeout field non-zero.
// - entering discharge clears the balance countdown.
// - during discharge switches follow the discharge switch select register.
// - during discharge a 4-bit heartbeat counts at 2 Hz and wraps.
// - pin three is driven high while the discharge countdown is active.
// - discharge alternates one-minute odd-cell and even-cell cycles.
// - each cycle ends with at least 62.5 ms of all switches off.
// - window field sets on-time in 7.5 s steps, capped below the minute.
// - timeout field gives duration 2*(n+1) hours; zero means disabled.
// - clearing enable resets the discharge timer and returns switch and pin control.
// - discharge also ends on zero timeout field or elapsed timeout.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module bwd_core
  import bwd_pkg::*;
#(
  parameter int CYC_PER_TICK = bwd_pkg::CYC_PER_TICK_DFLT
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [bwd_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [bwd_pkg::DATA_W-1:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [bwd_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [bwd_pkg::DATA_W-1:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [bwd_pkg::NUM_CELLS-1:0] o_bal_switch,
  output logic o_general_pin_three,
  output logic o_general_pin_three_oe
);
  import bwd_pkg::*;

  generate
    if (CYC_PER_TICK < 2) begin : g_chk
      $error("CYC_PER_TICK must be at least 2");
    end
    if (ST_SW_LSB + NUM_CELLS > ST_PIN_BIT) begin : g_map_chk
      $error("switch image overlaps the pin status bit");
    end
  endgenerate

  bwd_state_t r_reg;
  bwd_state_t r_next;
  logic base_tick;

  bwd_tick #(
    .CYC_PER_TICK(CYC_PER_TICK)
  ) u_tick (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .o_tick(base_tick)
  );

  // prescale period in seconds, zero when the timer is off
  function automatic logic [8:0] psc_period(input logic [2:0] sel);
    logic [8:0] p;
    p = '0;
    unique case (sel)
      3'h1: p = PSC_1S;
      3'h2: p = PSC_4S;
      3'h3: p = PSC_16S;
      3'h4: p = PSC_64S;
      3'h5: p = PSC_128S;
      3'h6: p = PSC_256S;
      default: p = '0;
    endcase
    return p;
  endfunction : psc_period

  // register read image
  function automatic logic [DATA_W-1:0] reg_read(input bwd_state_t s,
                                                   input logic [ADDR_W-1:0] a,
                                                   output logic hit);
    logic [DATA_W-1:0] d;
    d = '0;
    hit = 1'b1;
    unique case (a)
      OFS_BAL_EN: d[NUM_CELLS-1:0] = s.bal_en;
      OFS_WDOG: begin
        d[WDOG_PSEL_LSB +: 3] = s.psel;
        d[WDOG_CNT_LSB +: 4] = s.cnt;
      end
      OFS_PIN: begin
        d[PIN_TMR_SEL_BIT] = s.tmr_sel;
        d[PIN_LVL_BIT] = s.pin_lvl;
        d[PIN_OE_BIT] = s.pin_oe;
      end
      OFS_DCHG_SEL: d[NUM_CELLS-1:0] = s.dchg_sel;
      OFS_DCFG: begin
        d[DCFG_TIME_LSB +: 8] = s.dtime;
        d[DCFG_WIN_LSB +: 3] = s.dwin;
        d[DCFG_EN_BIT] = s.emg_en;
      end
      OFS_STATUS: begin
        d[ST_HB_LSB +: 4] = s.hb;
        d[ST_ACT_BIT] = s.emg_act;
        d[ST_DONE_BIT] = s.emg_done;
        d[ST_EXP_BIT] = (psc_period(s.psel) != '0) && (s.cnt == '0);
        d[ST_ODD_BIT] = s.odd;
        d[ST_SW_LSB +: NUM_CELLS] = s.sw;
        d[ST_PIN_BIT] = s.pin_o;
      end
      default: hit = 1'b0;
    endcase
    return d;
  endfunction : reg_read

  // merge write data into old word under byte strobes
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] wd,
                                                input logic [3:0] strb);
    logic [DATA_W-1:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  always_comb begin
    logic [DATA_W-1:0] old_w;
    logic [DATA_W-1:0] new_w;
    logic hit;
    logic rd_hit;
    logic [DATA_W-1:0] rd_w;
    logic [8:0] period;
    logic go;
    logic [10:0] on_ticks;
    logic win_on;
    logic wd_expired;
    old_w = '0;
    new_w = '0;
    hit = 1'b0;
    rd_hit = 1'b0;
    rd_w = '0;
    period = psc_period(r_reg.psel);
    go = 1'b0;
    on_ticks = '0;
    win_on = 1'b0;
    wd_expired = 1'b0;
    r_next = r_reg;

    // balancing watchdog prescaler and countdown
    if (period == '0) begin
      r_next.sub_sec = '0;
      r_next.sec_cnt = '0;
    end else if (base_tick) begin
      if (r_reg.sub_sec == TICKS_PER_SEC_M1) begin
        r_next.sub_sec = '0;
        if (r_reg.sec_cnt == period - 9'h001) begin
          r_next.sec_cnt = '0;
          if (r_reg.cnt != '0) begin
            r_next.cnt = r_reg.cnt - 4'h1;
          end
        end else begin
          r_next.sec_cnt = r_reg.sec_cnt + 9'h001;
        end
      end else begin
        r_next.sub_sec = r_reg.sub_sec + 4'h1;
      end
    end

    // axi write channel: address and data taken in either order
    if (r_reg.bvalid && i_s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.awready && i_s_axi_awvalid) begin
      r_next.aw_got = 1'b1;
      r_next.awaddr = i_s_axi_awaddr;
    end
    if (r_reg.wready && i_s_axi_wvalid) begin
      r_next.w_got = 1'b1;
      r_next.wdata = i_s_axi_wdata;
      r_next.wstrb = i_s_axi_wstrb;
    end
    if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
      old_w = reg_read(r_reg, r_reg.awaddr, hit);
      new_w = merge(old_w, r_reg.wdata, r_reg.wstrb);
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = hit ? RESP_OKAY : RESP_SLVERR;
      unique case (r_reg.awaddr)
        OFS_BAL_EN: r_next.bal_en = new_w[NUM_CELLS-1:0];
        OFS_WDOG: begin
          r_next.psel = new_w[WDOG_PSEL_LSB +: 3];
          if (r_reg.wstrb[0]) begin
            r_next.cnt = new_w[WDOG_CNT_LSB +: 4];
            r_next.sub_sec = '0;
            r_next.sec_cnt = '0;
          end
        end
        OFS_PIN: begin
          r_next.tmr_sel = new_w[PIN_TMR_SEL_BIT];
          r_next.pin_lvl = new_w[PIN_LVL_BIT];
          r_next.pin_oe = new_w[PIN_OE_BIT];
        end
        OFS_DCHG_SEL: r_next.dchg_sel = new_w[NUM_CELLS-1:0];
        OFS_DCFG: begin
          r_next.dtime = new_w[DCFG_TIME_LSB +: 8];
          r_next.dwin = new_w[DCFG_WIN_LSB +: 3];
          r_next.emg_en = new_w[DCFG_EN_BIT];
        end
        default: r_next.bresp = hit ? RESP_OKAY : RESP_SLVERR;
      endcase
    end
    // each ready drops while its item is held or the answer waits
    r_next.awready = !r_next.aw_got && !r_next.bvalid;
    r_next.wready = !r_next.w_got && !r_next.bvalid;

    // emergency discharge sequencer
    go = r_reg.emg_en && (r_reg.dtime != '0);
    if (!go) begin
      r_next.emg_act = 1'b0;
      r_next.emg_done = 1'b0;
      r_next.win_cnt = '0;
      r_next.hb_sub = '0;
      r_next.hb = '0;
      r_next.h2_cnt = '0;
      r_next.h2_units = '0;
      r_next.odd = 1'b1;
    end else if (!r_reg.emg_act && !r_reg.emg_done) begin
      r_next.emg_act = 1'b1;
      r_next.cnt = '0;
      r_next.win_cnt = '0;
      r_next.hb_sub = '0;
      r_next.hb = '0;
      r_next.h2_cnt = '0;
      r_next.h2_units = '0;
      r_next.odd = 1'b1;
    end else if (r_reg.emg_act && base_tick) begin
      r_next.cnt = '0;
      if (r_reg.win_cnt == TICKS_PER_MIN_M1) begin
        r_next.win_cnt = '0;
        r_next.odd = !r_reg.odd;
      end else begin
        r_next.win_cnt = r_reg.win_cnt + 10'h001;
      end
      // heartbeat wraps by itself after its top value
      if (r_reg.hb_sub == TICKS_PER_HB_M1) begin
        r_next.hb_sub = '0;
        r_next.hb = r_reg.hb + 4'h1;
      end else begin
        r_next.hb_sub = r_reg.hb_sub + 3'h1;
      end
      if (r_reg.h2_cnt == TICKS_PER_2H_M1) begin
        r_next.h2_cnt = '0;
        r_next.h2_units = r_reg.h2_units + 9'h001;
        if (r_reg.h2_units + 9'h001 == {1'b0, r_reg.dtime} + 9'h001) begin
          r_next.emg_act = 1'b0;
          r_next.emg_done = 1'b1;
        end
      end else begin
        r_next.h2_cnt = r_reg.h2_cnt + 17'h00001;
      end
    end
    // countdown stays cleared for the whole discharge, writes included
    if (r_reg.emg_act) begin
      r_next.cnt = '0;
    end

    // switch and pin outputs from the next state
    // last tick of every minute stays off, so phases never touch
    wd_expired = (psc_period(r_next.psel) != '0) && (r_next.cnt == '0);
    on_ticks = ({8'h00, r_next.dwin} + 11'h001) * TICKS_PER_WIN_STEP;
    if (on_ticks > {1'b0, TICKS_PER_MIN_M1}) begin
      on_ticks = {1'b0, TICKS_PER_MIN_M1};
    end
    win_on = {1'b0, r_next.win_cnt} < on_ticks;
    if (r_next.emg_act) begin
      r_next.sw = r_next.dchg_sel & (r_next.odd ? ODD_CELL_MASK : ~ODD_CELL_MASK)
                  & {NUM_CELLS{win_on}};
    end else if (wd_expired) begin
      r_next.sw = '0;
    end else begin
      r_next.sw = r_next.bal_en;
    end
    if (r_next.emg_act) begin
      r_next.pin_o = 1'b1;
      r_next.pin_oe_o = 1'b1;
    end else if (r_next.tmr_sel && (psc_period(r_next.psel) != '0) && (r_next.cnt != '0)) begin
      r_next.pin_o = 1'b1;
      r_next.pin_oe_o = 1'b1;
    end else begin
      // level only shows while the pin is driven
      r_next.pin_o = r_next.pin_lvl && r_next.pin_oe;
      r_next.pin_oe_o = r_next.pin_oe;
    end

    // axi read channel
    if (r_reg.rvalid && i_s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (r_reg.arready && i_s_axi_arvalid) begin
      rd_w = reg_read(r_reg, i_s_axi_araddr, rd_hit);
      r_next.rvalid = 1'b1;
      r_next.rdata = rd_w;
      r_next.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    r_next.arready = !r_next.rvalid;
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_s_axi_awready = r_reg.awready;
  assign o_s_axi_wready = r_reg.wready;
  assign o_s_axi_bvalid = r_reg.bvalid;
  assign o_s_axi_bresp = r_reg.bresp;
  assign o_s_axi_arready = r_reg.arready;
  assign o_s_axi_rvalid = r_reg.rvalid;
  assign o_s_axi_rresp = r_reg.rresp;
  assign o_s_axi_rdata = r_reg.rdata;
  assign o_bal_switch = r_reg.sw;
  assign o_general_pin_three = r_reg.pin_o;
  assign o_general_pin_three_oe = r_reg.pin_oe_o;
endmodule : bwd_core

// ---- testbench/bwd_core_checker.sv ----
`timescale 1ns/1ps
module bwd_core_checker
  import bwd_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [bwd_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic [bwd_pkg::DATA_W-1:0] i_s_axi_wdata,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic [bwd_pkg::NUM_CELLS-1:0] o_bal_switch,
  input wire logic o_general_pin_three,
  input wire logic o_general_pin_three_oe
);
  // shadow of the written configuration
  logic [7:0] a_q;
  logic [31:0] d_q;
  logic bv_q;
  logic [11:0] bal_q;
  logic [11:0] dsel_q;
  logic [2:0] psel_q;
  logic [16:0] cfg_q;
  logic emg_run;
  logic b_new;
  logic [11:0] bal_eff;
  logic [11:0] dsel_eff;
  logic [2:0] psel_eff;
  assign emg_run = cfg_q[16] && (cfg_q[7:0] != 8'h00);
  assign b_new = o_s_axi_bvalid && !bv_q;
  // shadow as seen in the cycle the design applies the write
  assign bal_eff = (b_new && a_q == OFS_BAL_EN) ? d_q[11:0] : bal_q;
  assign dsel_eff = (b_new && a_q == OFS_DCHG_SEL) ? d_q[11:0] : dsel_q;
  assign psel_eff = (b_new && a_q == OFS_WDOG) ? d_q[2:0] : psel_q;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      a_q <= 8'h00;
      d_q <= 32'h0;
      bv_q <= 1'b0;
      bal_q <= 12'h000;
      dsel_q <= 12'h000;
      psel_q <= 3'h0;
      cfg_q <= 17'h0;
    end else begin
      bv_q <= o_s_axi_bvalid;
      if (i_s_axi_awvalid && o_s_axi_awready) a_q <= i_s_axi_awaddr;
      if (i_s_axi_wvalid && o_s_axi_wready) d_q <= i_s_axi_wdata;
      if (o_s_axi_bvalid && !bv_q) begin
        case (a_q)
          OFS_BAL_EN: bal_q <= d_q[11:0];
          OFS_WDOG: psel_q <= d_q[2:0];
          OFS_DCHG_SEL: dsel_q <= d_q[11:0];
          OFS_DCFG: cfg_q <= d_q[16:0];
          default: ;
        endcase
      end
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  AST_AW_TAKEN:
    assert property (i_s_axi_awvalid && o_s_axi_awready |=> !o_s_axi_awready)
      else $error("awready stayed high after address taken");
  AST_B_AFTER:
    assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
      |-> ##[1:3] o_s_axi_bvalid) else $error("write response missing");
  AST_B_DONE:
    assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
      else $error("bvalid held after handshake");
  AST_R_AFTER:
    assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
      else $error("read data not one cycle after address");
  AST_AR_BLOCK:
    assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
      else $error("arready high while read data pending");
  AST_PIN_DRIVEN:
    assert property (o_general_pin_three |-> o_general_pin_three_oe)
      else $error("pin three high without output enable");
  AST_SW_NORMAL:
    assert property ((!cfg_q[16] && psel_eff == 3'h0)[*4] |-> o_bal_switch == bal_eff)
      else $error("switches differ from enable register");
  AST_SW_MASK:
    assert property (emg_run[*4] |-> (o_bal_switch & ~dsel_eff) == 12'h000)
      else $error("discharge switch outside select mask");
  AST_SW_NOOVL:
    assert property (emg_run[*4] |->
      !((|(o_bal_switch & ODD_CELL_MASK)) && (|(o_bal_switch & ~ODD_CELL_MASK))))
      else $error("odd and even switches on together");
endmodule : bwd_core_checker

bind bwd_core bwd_core_checker u_chk (
  .i_clk_sys(i_clk_sys),
  .i_rstn(i_rstn),
  .i_s_axi_awaddr(i_s_axi_awaddr),
  .i_s_axi_awvalid(i_s_axi_awvalid),
  .o_s_axi_awready(o_s_axi_awready),
  .i_s_axi_wdata(i_s_axi_wdata),
  .i_s_axi_wvalid(i_s_axi_wvalid),
  .o_s_axi_wready(o_s_axi_wready),
  .o_s_axi_bvalid(o_s_axi_bvalid),
  .i_s_axi_bready(i_s_axi_bready),
  .i_s_axi_arvalid(i_s_axi_arvalid),
  .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_rvalid(o_s_axi_rvalid),
  .o_bal_switch(o_bal_switch),
  .o_general_pin_three(o_general_pin_three),
  .o_general_pin_three_oe(o_general_pin_three_oe)
);

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import bwd_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic arv = 1'b0;
  logic bready = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin, oe;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [11:0] sw;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;

  always #20 clk = ~clk;

  bwd_core #(.CYC_PER_TICK(4)) uut (
    .i_clk_sys(clk), .i_rstn(rstn),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awv), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_bal_switch(sw),
    .o_general_pin_three(pin), .o_general_pin_three_oe(oe)
  );

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while ((awv && !awready) || (wv && !wready));
    while (!bvalid) @(posedge clk);
    chk(bresp, er, "bresp");
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arv <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    chk(rresp, er, "rresp");
    rready <= 1'b0;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input logic [1:0] er);
    logic [31:0] v;
    rd(a, v, er);
    chk(v & m, e, "read");
  endtask : rdc

  task automatic t_regs();
    wr(OFS_BAL_EN, 32'h0000_0abc, RESP_OKAY);
    rdc(OFS_BAL_EN, 32'hffff_ffff, 32'h0000_0abc, RESP_OKAY);
    wr(8'h40, 32'h0000_0001, RESP_SLVERR);
    rdc(8'h40, 32'hffff_ffff, 32'h0, RESP_SLVERR);
    wt(2);
    chk(sw, 32'habc, "switch follow");
    rdc(OFS_STATUS, 32'hffff_ff7f, 32'h000a_bc00, RESP_OKAY);
    $display("test regs done");
  endtask : t_regs

  task automatic t_wdog();
    int per[6] = '{1, 4, 16, 64, 128, 256};
    for (int i = 0; i < 4; i++) begin
      wr(OFS_WDOG, 32'h11, RESP_OKAY);
      wt(40);
      chk(sw, 32'habc, "periodic reload");
    end
    for (int k = 0; k < 6; k++) begin
      wr(OFS_WDOG, 32'h10 | (k + 1), RESP_OKAY);
      wt(per[k] * 48);
      chk(sw, 32'habc, "before expiry");
      wt(per[k] * 32);
      chk(sw, 32'h0, "after expiry");
    end
    rdc(OFS_BAL_EN, 32'hfff, 32'habc, RESP_OKAY);
    rdc(OFS_STATUS, 32'h40, 32'h40, RESP_OKAY);
    wr(OFS_PIN, 32'h1, RESP_OKAY);
    wt(2);
    chk({pin, oe}, 32'h0, "pin after expiry");
    chk(sw, 32'h0, "still off");
    wr(OFS_WDOG, 32'h21, RESP_OKAY);
    wt(4);
    chk(sw, 32'habc, "reload on");
    chk({pin, oe}, 32'h3, "pin while counting");
    wt(160);
    chk(sw, 32'h0, "two second expiry");
    chk({pin, oe}, 32'h0, "pin released");
    wr(OFS_WDOG, 32'h0, RESP_OKAY);
    wt(3);
    chk(sw, 32'habc, "timer disabled");
    wr(OFS_PIN, 32'h0, RESP_OKAY);
    $display("test watchdog done");
  endtask : t_wdog

  task automatic t_emg();
    logic [31:0] h1, h2;
    wr(OFS_WDOG, 32'h50, RESP_OKAY);
    wr(OFS_DCHG_SEL, 32'h7ff, RESP_OKAY);
    wr(OFS_DCFG, 32'h0001_0000, RESP_OKAY);
    wt(4);
    rdc(OFS_STATUS, 32'h10, 32'h0, RESP_OKAY);
    chk(sw, 32'habc, "no start");
    wr(OFS_DCFG, 32'h0001_0001, RESP_OKAY);
    wt(100);
    chk(sw, 32'h555, "odd window");
    chk({pin, oe}, 32'h3, "pin in discharge");
    rdc(OFS_WDOG, 32'hf0, 32'h0, RESP_OKAY);
    rd(OFS_STATUS, h1, RESP_OKAY);
    wt(61);
    rd(OFS_STATUS, h2, RESP_OKAY);
    chk((h2 - h1) & 32'hf, 32'h2, "heartbeat rate");
    wt(400);
    chk(sw, 32'h0, "window off");
    wt(3340);
    chk(sw, 32'h2aa, "even window");
    wr(OFS_DCFG, 32'h0001_0000, RESP_OKAY);
    wt(4);
    chk(sw, 32'habc, "zero timeout end");
    chk({pin, oe}, 32'h0, "zero timeout pin");
    rdc(OFS_STATUS, 32'h10, 32'h0, RESP_OKAY);
    wr(OFS_DCFG, 32'h0001_0101, RESP_OKAY);
    wt(20);
    rdc(OFS_STATUS, 32'h10, 32'h10, RESP_OKAY);
    wt(600);
    chk(sw, 32'h555, "second window step");
    wr(OFS_DCFG, 32'h0000_0101, RESP_OKAY);
    wt(4);
    chk(sw, 32'habc, "enable cleared");
    chk({pin, oe}, 32'h0, "pin reverted");
    rdc(OFS_STATUS, 32'h10, 32'h0, RESP_OKAY);
    $display("test discharge done");
  endtask : t_emg

  initial begin
    wt(4);
    rstn <= 1'b1;
    wt(2);
    t_regs();
    t_wdog();
    t_emg();
    final_report();
  end
endmodule : tb_top
